// File: pcg_port_c.sv
// Port C GPIO block: pin muxing, pull-ups, change interrupt and an Avalon-MM register slave.
`timescale 1ns/1ns
module pcg_port_c #(
  parameter int unsigned ADDR_WIDTH = 10
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [ADDR_WIDTH-1:0] avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [3:0]  avsByteEnable,
  input  wire logic [31:0] avsWriteData,
  output logic      [31:0] avsReadData,
  output logic             avsWaitRequest,
  input  wire logic [7:0]  pinIn,
  output logic      [7:0]  pinOut,
  output logic      [7:0]  pinOe_n,
  output logic      [5:0]  weakPullupEn,
  output logic      [1:0]  nchPullupEn,
  input  wire logic        hibernate,
  input  wire logic        sleepMode,
  output logic             wakeRequest,
  output logic             irq,
  input  wire logic        progMode,
  input  wire logic        serialDataOut,
  input  wire logic        serialDataOe_n,
  input  wire logic        serialClockOut,
  input  wire logic        serialClockOe_n,
  output logic             serialDataIn,
  output logic             serialClockIn,
  input  wire logic        compAOut,
  output logic             refAOutEn,
  output logic             timerZeroExtClock
);

  // The register index needs eight address bits above the two byte bits.
  initial begin
    if (ADDR_WIDTH < pcg_pkg::INDEX_WIDTH + pcg_pkg::BYTE_SHIFT) begin
      $error("ADDR_WIDTH too small for the register map.");
    end
  end

  // Register state and next values.
  logic [7:0]  dirR,      dirNxt;      // Direction, one means input.
  logic [7:0]  latchR,    latchNxt;    // Output latches.
  logic [7:0]  optionR,   optionNxt;   // Pull-up disable and timer source.
  logic [7:0]  compR,     compNxt;     // Comparator control.
  logic [7:0]  twoWireR,  twoWireNxt;  // Two-wire control.
  logic [7:0]  flagR,     flagNxt;     // Sticky event status.
  logic [7:0]  enableR,   enableNxt;   // Interrupt enables.
  logic [7:0]  snapR,     snapNxt;     // Pin levels captured at the last port read.
  logic [31:0] rdataR,    rdataNxt;    // Read data held for the answer.
  logic        ackR,      ackNxt;      // High in the cycle the answer is given.

  // Pin synchroniser and filtered level.
  logic [7:0]  sync1R, sync2R, sync3R; // Three-stage input synchroniser.
  logic [7:0]  pinFiltR, pinFiltNxt;   // Level taken once stages two and three agree.

  // Registered pin-facing outputs.
  logic [7:0]  pinOutR,   pinOutNxt;
  logic [7:0]  pinOeNR,   pinOeNNxt;
  logic [5:0]  pullupR,   pullupNxt;
  logic [1:0]  nchR,      nchNxt;
  logic        refAR,     refANxt;
  logic        timerR,    timerNxt;
  logic        serDataR,  serDataNxt;
  logic        serClockR, serClockNxt;

  // Decoded access and status terms.
  logic [7:0]  regIndex;     // Word index of the access.
  logic        request;      // A read or a write is on the bus.
  logic        accept;       // The request completes at this edge.
  logic        takeRead;     // First cycle of a read, where data is captured.
  logic        wrLane0;      // Write that carries the low byte.
  logic        twoWireOn;    // Two-wire function enabled.
  logic        serialOwned;  // Pins 7 and 6 belong to the serial function.
  logic        compAOn;      // Comparator A outputs take pins 1 and 0.
  logic [7:0]  eligible;     // Pins that take part in change detection.
  logic        mismatch;     // Some eligible pin differs from the snapshot.

  assign regIndex    = avsAddress[pcg_pkg::BYTE_SHIFT +: pcg_pkg::INDEX_WIDTH];
  assign request     = avsRead | avsWrite;
  assign accept      = request & ackR;
  assign takeRead    = avsRead & ~ackR;
  assign wrLane0     = avsWrite & ~ackR & avsByteEnable[0];
  assign twoWireOn   = twoWireR[pcg_pkg::BIT_TWO_WIRE_ENABLE];
  assign serialOwned = twoWireOn | progMode;
  assign compAOn     = compR[pcg_pkg::BIT_COMP_A_OE];

  // The answer always comes one cycle after the request; a fixed wait keeps the master simple.
  assign avsWaitRequest = request & ~ackR;
  assign avsReadData    = rdataR;

  // Change detection covers only input pins 7..4, minus the serial pair in two-wire mode.
  always_comb begin
    eligible = 8'h00;
    eligible[7:pcg_pkg::CHANGE_LOW_PIN] = dirR[7:pcg_pkg::CHANGE_LOW_PIN];
    if (twoWireOn) begin
      eligible[pcg_pkg::SERIAL_DATA_PIN]  = 1'b0;
      eligible[pcg_pkg::SERIAL_CLOCK_PIN] = 1'b0;
    end
    mismatch = |((pinFiltR ^ snapR) & eligible);
  end

  // Interrupt and wake are levels from the sticky status gated by the enables.
  assign irq         = |(flagR & enableR);
  assign wakeRequest = sleepMode & irq;

  // Bus-side next values: register writes, read capture and the answer handshake.
  always_comb begin
    dirNxt     = dirR;
    latchNxt   = latchR;
    optionNxt  = optionR;
    compNxt    = compR;
    twoWireNxt = twoWireR;
    enableNxt  = enableR;
    snapNxt    = snapR;
    rdataNxt   = rdataR;
    ackNxt     = request & ~ackR;
    flagNxt    = flagR;
    // Writes take effect in the first request cycle; the master holds them until the answer.
    if (wrLane0) begin
      unique case (regIndex)
        pcg_pkg::IDX_PIN_DATA:   latchNxt   = avsWriteData[7:0];
        pcg_pkg::IDX_DIRECTION:  dirNxt     = avsWriteData[7:0];
        pcg_pkg::IDX_OPTION:     optionNxt  = avsWriteData[7:0];
        pcg_pkg::IDX_COMPARATOR: compNxt    = avsWriteData[7:0];
        pcg_pkg::IDX_TWO_WIRE:   twoWireNxt = avsWriteData[7:0];
        pcg_pkg::IDX_ENABLE_ONE: enableNxt  = avsWriteData[7:0];
        pcg_pkg::IDX_FLAG_CLEAR: flagNxt    = flagR & ~avsWriteData[7:0];
        default: begin
          // Unmapped or read-only index: the write is dropped.
          latchNxt = latchR;
        end
      endcase
    end
    // A persisting mismatch sets the flag again, so a set always beats a clear.
    if (mismatch) begin
      flagNxt[pcg_pkg::BIT_PORT_CHANGE] = 1'b1;
    end
    // Reads capture their data in the first cycle; unmapped indices read as zero.
    if (takeRead) begin
      rdataNxt = 32'h0000_0000;
      unique case (regIndex)
        pcg_pkg::IDX_PIN_DATA: begin
          rdataNxt[7:0] = pinFiltR;
          snapNxt       = pinFiltR;
        end
        pcg_pkg::IDX_DIRECTION:  rdataNxt[7:0] = dirR;
        pcg_pkg::IDX_OPTION:     rdataNxt[7:0] = optionR;
        pcg_pkg::IDX_COMPARATOR: rdataNxt[7:0] = compR;
        pcg_pkg::IDX_TWO_WIRE:   rdataNxt[7:0] = twoWireR;
        pcg_pkg::IDX_FLAG_ONE:   rdataNxt[7:0] = flagR;
        pcg_pkg::IDX_ENABLE_ONE: rdataNxt[7:0] = enableR;
        default: begin
          // The clear register is write-only and reads as zero too.
          rdataNxt = 32'h0000_0000;
        end
      endcase
    end
  end

  // Bus-side registers; the latches get a defined value although software may not rely on it.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dirR     <= pcg_pkg::RST_DIRECTION;
      latchR   <= pcg_pkg::RST_LATCH;
      optionR  <= pcg_pkg::RST_OPTION;
      compR    <= pcg_pkg::RST_COMPARATOR;
      twoWireR <= pcg_pkg::RST_TWO_WIRE;
      flagR    <= pcg_pkg::RST_FLAG;
      enableR  <= pcg_pkg::RST_ENABLE;
      snapR    <= 8'h00;
      rdataR   <= 32'h0000_0000;
      ackR     <= 1'b0;
    end else begin
      dirR     <= dirNxt;
      latchR   <= latchNxt;
      optionR  <= optionNxt;
      compR    <= compNxt;
      twoWireR <= twoWireNxt;
      flagR    <= flagNxt;
      enableR  <= enableNxt;
      snapR    <= snapNxt;
      rdataR   <= rdataNxt;
      ackR     <= ackNxt;
    end
  end

  // The filtered level follows the pin only when stages two and three agree, which rejects a one-cycle glitch.
  always_comb begin
    pinFiltNxt = (sync3R & ~(sync2R ^ sync3R)) | (pinFiltR & (sync2R ^ sync3R));
  end

  // Synchroniser and filter registers; stage one is read only by stage two.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1R   <= 8'h00;
      sync2R   <= 8'h00;
      sync3R   <= 8'h00;
      pinFiltR <= 8'h00;
    end else begin
      sync1R   <= pinIn;
      sync2R   <= sync1R;
      sync3R   <= sync2R;
      pinFiltR <= pinFiltNxt;
    end
  end

  // Per-pin drive: direction and latch, with the alternate functions taking over their pins.
  genvar gi;
  generate
    for (gi = 0; gi < pcg_pkg::PORT_WIDTH; gi++) begin : gPin
      always_comb begin
        pinOutNxt[gi] = latchR[gi];
        pinOeNNxt[gi] = dirR[gi];
        if (gi == pcg_pkg::SERIAL_DATA_PIN && serialOwned) begin
          pinOutNxt[gi] = serialDataOut;
          pinOeNNxt[gi] = serialDataOe_n;
        end else if (gi == pcg_pkg::SERIAL_CLOCK_PIN && serialOwned) begin
          pinOutNxt[gi] = serialClockOut;
          pinOeNNxt[gi] = serialClockOe_n;
        end else if (gi == pcg_pkg::COMP_A_PIN && compAOn) begin
          pinOutNxt[gi] = compAOut;
          pinOeNNxt[gi] = 1'b0;
        end else if (gi == pcg_pkg::REF_A_PIN && compAOn) begin
          // The analog reference drives this pin, so the digital driver lets go.
          pinOutNxt[gi] = 1'b0;
          pinOeNNxt[gi] = 1'b1;
        end
      end
    end
  endgenerate

  // Pull-ups, alternate inputs and the timer clock route.
  always_comb begin
    // The shared bit is active low; hibernate overrides it and the other weak pull-up terms, not the N-channel pull-ups.
    pullupNxt = dirR[5:0] & latchR[5:0] & {pcg_pkg::PULLUP_PINS{~optionR[pcg_pkg::BIT_PULLUP_DISABLE_N]}};
    if (hibernate) begin
      pullupNxt = 6'h00;
    end
    nchNxt      = twoWireOn ? 2'h0 : 2'h3;
    refANxt     = compAOn;
    serDataNxt  = pinFiltR[pcg_pkg::SERIAL_DATA_PIN];
    serClockNxt = pinFiltR[pcg_pkg::SERIAL_CLOCK_PIN];
    // Unselected, the timer input rests low so it cannot count pin noise.
    timerNxt = optionR[pcg_pkg::BIT_TIMER_EXT_SELECT] & pinFiltR[pcg_pkg::TIMER_CLOCK_PIN];
  end

  // Pin-facing output registers; after reset every pin floats with weak pull-ups off and the N-channel pull-ups on.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pinOutR   <= 8'h00;
      pinOeNR   <= 8'hFF;
      pullupR   <= 6'h00;
      nchR      <= 2'h3;
      refAR     <= 1'b0;
      timerR    <= 1'b0;
      serDataR  <= 1'b0;
      serClockR <= 1'b0;
    end else begin
      pinOutR   <= pinOutNxt;
      pinOeNR   <= pinOeNNxt;
      pullupR   <= pullupNxt;
      nchR      <= nchNxt;
      refAR     <= refANxt;
      timerR    <= timerNxt;
      serDataR  <= serDataNxt;
      serClockR <= serClockNxt;
    end
  end

  assign pinOut            = pinOutR;
  assign pinOe_n           = pinOeNR;
  assign weakPullupEn      = pullupR;
  assign nchPullupEn       = nchR;
  assign refAOutEn         = refAR;
  assign timerZeroExtClock = timerR;
  assign serialDataIn      = serDataR;
  assign serialClockIn     = serClockR;

  // Checks on the bus handshake.
  busAnswer_a: assert property (@(posedge clock) disable iff (!reset_n)
    (request && avsWaitRequest) |=> !avsWaitRequest)
    else $error("Bus answer did not follow one wait cycle.");

  dirWrite_a: assert property (@(posedge clock) disable iff (!reset_n)
    (wrLane0 && regIndex == pcg_pkg::IDX_DIRECTION) |=> (dirR == $past(avsWriteData[7:0])))
    else $error("Direction write not stored.");

  readPins_a: assert property (@(posedge clock) disable iff (!reset_n)
    (accept && avsRead && regIndex == pcg_pkg::IDX_PIN_DATA) |-> (avsReadData[7:0] == $past(pinFiltR)))
    else $error("Port read did not return pin levels.");

  // Checks on pin drive and pull-ups.
  outputDrive_a: assert property (@(posedge clock) disable iff (!reset_n)
    (!dirR[2]) |=> (!pinOe_n[2] && pinOut[2] == $past(latchR[2])))
    else $error("Output pin not driven from latch.");

  hibernateOff_a: assert property (@(posedge clock) disable iff (!reset_n)
    hibernate |=> (weakPullupEn == 6'h00))
    else $error("Pull-up on during hibernate.");

  pullupInput_a: assert property (@(posedge clock) disable iff (!reset_n)
    (!dirR[3] || !latchR[3] || optionR[pcg_pkg::BIT_PULLUP_DISABLE_N]) |=> !weakPullupEn[3])
    else $error("Pull-up on a pin that must not have it.");

  compOverride_a: assert property (@(posedge clock) disable iff (!reset_n)
    compAOn |=> (pinOe_n[0] && !pinOe_n[1] && pinOut[1] == $past(compAOut) && refAOutEn))
    else $error("Comparator A did not take pins 1 and 0.");

  nchTwoWire_a: assert property (@(posedge clock) disable iff (!reset_n)
    twoWireOn |=> (nchPullupEn == 2'h0))
    else $error("N-channel pull-up on in two-wire mode.");

  timerRoute_a: assert property (@(posedge clock) disable iff (!reset_n)
    !optionR[pcg_pkg::BIT_TIMER_EXT_SELECT] |=> !timerZeroExtClock)
    else $error("Timer clock routed while not selected.");

  // Checks on change detection and the interrupt.
  flagCause_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(flagR[pcg_pkg::BIT_PORT_CHANGE]) |-> $past(|((pinFiltR ^ snapR) & dirR & 8'hF0 &
      (twoWireOn ? 8'h3F : 8'hFF))))
    else $error("Change flag set without an eligible mismatch.");

  setWins_a: assert property (@(posedge clock) disable iff (!reset_n)
    mismatch |=> flagR[pcg_pkg::BIT_PORT_CHANGE])
    else $error("Mismatch did not keep the change flag set.");

  irqWake_a: assert property (@(posedge clock) disable iff (!reset_n)
    (flagR[pcg_pkg::BIT_PORT_CHANGE] && enableR[pcg_pkg::BIT_PORT_CHANGE] && sleepMode) |-> (irq && wakeRequest))
    else $error("Enabled change did not interrupt and wake.");

endmodule

// File: pcg_pkg.sv
// Package with register indices, field positions, reset values and timing counts of the port C GPIO block.
package pcg_pkg;

  // Port width and the word-index to byte-address scale of the register bus.
  localparam int unsigned PORT_WIDTH   = 8;
  localparam int unsigned INDEX_WIDTH  = 8;
  localparam int unsigned BYTE_SHIFT   = 2;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_PIN_DATA     = 8'h07;
  localparam logic [7:0] IDX_DIRECTION    = 8'h87;
  localparam logic [7:0] IDX_TWO_WIRE     = 8'h14;
  localparam logic [7:0] IDX_FLAG_ONE     = 8'h0C;
  localparam logic [7:0] IDX_FLAG_CLEAR   = 8'h0D;
  localparam logic [7:0] IDX_ENABLE_ONE   = 8'h8C;
  localparam logic [7:0] IDX_OPTION       = 8'h81;
  localparam logic [7:0] IDX_COMPARATOR   = 8'h1F;

  // Field positions.
  localparam int unsigned BIT_PULLUP_DISABLE_N = 7;
  localparam int unsigned BIT_TIMER_EXT_SELECT = 5;
  localparam int unsigned BIT_COMP_A_OE        = 1;
  localparam int unsigned BIT_TWO_WIRE_ENABLE  = 5;
  localparam int unsigned BIT_PORT_CHANGE      = 2;
  localparam int unsigned PULLUP_PINS          = 6;
  localparam int unsigned CHANGE_LOW_PIN       = 4;
  localparam int unsigned SERIAL_DATA_PIN      = 7;
  localparam int unsigned SERIAL_CLOCK_PIN     = 6;
  localparam int unsigned REF_A_PIN            = 0;
  localparam int unsigned COMP_A_PIN           = 1;
  localparam int unsigned TIMER_CLOCK_PIN      = 3;

  // Reset values.
  localparam logic [7:0] RST_DIRECTION  = 8'hFF;
  localparam logic [7:0] RST_LATCH      = 8'h00;
  localparam logic [7:0] RST_OPTION     = 8'hFF;
  localparam logic [7:0] RST_COMPARATOR = 8'h00;
  localparam logic [7:0] RST_TWO_WIRE   = 8'h00;
  localparam logic [7:0] RST_FLAG       = 8'h00;
  localparam logic [7:0] RST_ENABLE     = 8'h00;

  // Bus timing: cycles of waitrequest before every answer.
  localparam int unsigned BUS_WAIT_CYCLES = 1;

endpackage

// File: pcg_board_model.sv
// Board model for the port C pins: resolves each pin from the block's drivers, board drivers and pull-ups.
`timescale 1ns/1ns
module pcg_board_model (
  input  wire logic       clock,
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe_n,
  input  wire logic [5:0] weakPullupEn,
  input  wire logic [1:0] nchPullupEn,
  input  wire logic [7:0] extValue,
  input  wire logic [7:0] extEnable,
  output logic      [7:0] pinLevel
);
  logic [7:0] floatR = 8'h55;  // Pattern seen on an undriven pin.
  logic [7:0] floatNxt;        // Next pattern, every bit flips.
  logic [7:0] pullUp;          // Pull-up per pin, N-channel ones on pins 7 and 6.

  // A floating pin must not look stable, so its level changes every cycle.
  always_comb begin
    floatNxt = ~floatR;
  end

  // Register the floating pattern.
  always_ff @(posedge clock) begin
    floatR <= floatNxt;
  end

  assign pullUp = {nchPullupEn, weakPullupEn};

  // The block's own driver wins over the board, so contention is never hidden as a board value.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOe_n[i] == 1'b0) begin
        pinLevel[i] = pinOut[i];
      end else if (extEnable[i]) begin
        pinLevel[i] = extValue[i];
      end else if (pullUp[i]) begin
        pinLevel[i] = 1'b1;
      end else begin
        pinLevel[i] = floatR[i];
      end
    end
  end
endmodule

// File: testbench.sv
// Self-checking testbench of the port C GPIO block with a board model on its pins.
`timescale 1ns/1ns
`define CHECK(got, exp) begin \
  totalChecks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("BAD time=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module testbench;
  logic        clock;
  logic        reset_n;
  logic [9:0]  avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [3:0]  avsByteEnable;
  logic [31:0] avsWriteData;
  logic [31:0] avsReadData;
  logic        avsWaitRequest;
  logic [7:0]  pinLevel;
  logic [7:0]  pinOut;
  logic [7:0]  pinOe_n;
  logic [5:0]  weakPullupEn;
  logic [1:0]  nchPullupEn;
  logic        hibernate;
  logic        sleepMode;
  logic        wakeRequest;
  logic        irq;
  logic        progMode;
  logic        serialDataOut;
  logic        serialDataOe_n;
  logic        serialClockOut;
  logic        serialClockOe_n;
  logic        serialDataIn;
  logic        serialClockIn;
  logic        compAOut;
  logic        refAOutEn;
  logic        timerZeroExtClock;
  logic [7:0]  extValue;    // Level that the board drives on input pins.
  logic [7:0]  extEnable;   // Pins that the board drives; the others float or are pulled up.
  int          mismatches;  // Failed comparisons.
  int          totalChecks; // All comparisons.

  pcg_port_c #(.ADDR_WIDTH(10)) pcg_port_c_inst (
    .clock(clock), .reset_n(reset_n), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsByteEnable(avsByteEnable), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .pinIn(pinLevel), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .weakPullupEn(weakPullupEn), .nchPullupEn(nchPullupEn), .hibernate(hibernate), .sleepMode(sleepMode),
    .wakeRequest(wakeRequest), .irq(irq), .progMode(progMode), .serialDataOut(serialDataOut),
    .serialDataOe_n(serialDataOe_n), .serialClockOut(serialClockOut), .serialClockOe_n(serialClockOe_n),
    .serialDataIn(serialDataIn), .serialClockIn(serialClockIn), .compAOut(compAOut),
    .refAOutEn(refAOutEn), .timerZeroExtClock(timerZeroExtClock));

  pcg_board_model pcg_board_model_inst (
    .clock(clock), .pinOut(pinOut), .pinOe_n(pinOe_n), .weakPullupEn(weakPullupEn),
    .nchPullupEn(nchPullupEn), .extValue(extValue), .extEnable(extEnable), .pinLevel(pinLevel));

  // Free-running 50 MHz clock.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One bus transfer entered just after an edge; the request holds until waitrequest is low at an edge.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    avsAddress   <= {idx, 2'h0};
    avsWriteData <= {24'h000000, wd};
    avsWrite     <= wr;
    avsRead      <= ~wr;
    do begin
      @(posedge clock);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
    // A slave that never answers ends the run as a failure.
    if (n >= 50) begin
      mismatches++;
      end_sim();
    end
    @(posedge clock);
  endtask

  // Register write.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] unused;
    bus(1'b1, idx, d, unused);
  endtask

  // Register read compared with an expected word.
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 8'h00, d);
    `CHECK(d, exp)
  endtask

  // Waits whole cycles; the pin filter settles within four and the flag one later.
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Main sequence.
  initial begin
    mismatches = 0;
    totalChecks = 0;
    reset_n = 1'b0;
    avsAddress = 10'h000;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsByteEnable = 4'hF;
    avsWriteData = 32'h00000000;
    hibernate = 1'b0;
    sleepMode = 1'b0;
    progMode = 1'b0;
    serialDataOut = 1'b1;
    serialDataOe_n = 1'b1;
    serialClockOut = 1'b1;
    serialClockOe_n = 1'b1;
    compAOut = 1'b0;
    extValue = 8'h00;
    extEnable = 8'hFF;
    idle(10);
    reset_n <= 1'b1;
    @(posedge clock);
    // Reset state: all inputs, no weak pull-ups.
    `CHECK(pinOe_n, 8'hFF)
    `CHECK(weakPullupEn, 6'h00)
    rdc(pcg_pkg::IDX_DIRECTION, 32'h000000FF);
    rdc(8'h10, 32'h00000000);
    // Latches first, then direction; high nibble becomes output.
    wr(pcg_pkg::IDX_PIN_DATA, 8'hA5);
    wr(pcg_pkg::IDX_DIRECTION, 8'h0F);
    idle(2);
    `CHECK(pinOe_n, 8'h0F)
    `CHECK(pinOut[7:4], 4'hA)
    idle(8);
    rdc(pcg_pkg::IDX_FLAG_ONE, 32'h00000000);
    rdc(pcg_pkg::IDX_PIN_DATA, 32'h000000A0);
    rdc(pcg_pkg::IDX_DIRECTION, 32'h0000000F);
    // Pull-ups only on input pins whose latch is one.
    wr(pcg_pkg::IDX_OPTION, 8'h7F);
    idle(2);
    `CHECK(weakPullupEn, 6'h05)
    // The board lets go of the low pins, so the pull-ups must hold pins 2 and 0 high.
    extEnable <= 8'hF0;
    idle(2);
    `CHECK({pinLevel[2], pinLevel[0]}, 2'b11)
    extEnable <= 8'hFF;
    hibernate <= 1'b1;
    idle(2);
    `CHECK(weakPullupEn, 6'h00)
    hibernate <= 1'b0;
    idle(2);
    `CHECK(weakPullupEn, 6'h05)
    // Change interrupt on pin 5 while asleep.
    wr(pcg_pkg::IDX_DIRECTION, 8'hFF);
    idle(8);
    `CHECK(weakPullupEn, 6'h25)
    rdc(pcg_pkg::IDX_PIN_DATA, 32'h00000000);
    wr(pcg_pkg::IDX_FLAG_CLEAR, 8'h04);
    wr(pcg_pkg::IDX_ENABLE_ONE, 8'h04);
    sleepMode <= 1'b1;
    extValue <= 8'h20;
    idle(8);
    `CHECK(irq, 1'b1)
    `CHECK(wakeRequest, 1'b1)
    rdc(pcg_pkg::IDX_FLAG_ONE, 32'h00000004);
    // The flag cannot be cleared while the mismatch lasts.
    wr(pcg_pkg::IDX_FLAG_CLEAR, 8'h04);
    rdc(pcg_pkg::IDX_FLAG_ONE, 32'h00000004);
    wr(pcg_pkg::IDX_ENABLE_ONE, 8'h00);
    `CHECK(irq, 1'b0)
    wr(pcg_pkg::IDX_ENABLE_ONE, 8'h04);
    rdc(pcg_pkg::IDX_PIN_DATA, 32'h00000020);
    wr(pcg_pkg::IDX_FLAG_CLEAR, 8'h04);
    rdc(pcg_pkg::IDX_FLAG_ONE, 32'h00000000);
    `CHECK(irq, 1'b0)
    sleepMode <= 1'b0;
    // Two-wire mode owns pins 7 and 6 and hides them from the comparison.
    wr(pcg_pkg::IDX_TWO_WIRE, 8'h20);
    extValue <= 8'hA0;
    idle(8);
    `CHECK(nchPullupEn, 2'h0)
    `CHECK(serialDataIn, 1'b1)
    rdc(pcg_pkg::IDX_FLAG_ONE, 32'h00000000);
    serialDataOut <= 1'b0;
    serialDataOe_n <= 1'b0;
    idle(2);
    `CHECK({pinOe_n[7], pinOut[7]}, 2'b00)
    serialDataOe_n <= 1'b1;
    wr(pcg_pkg::IDX_TWO_WIRE, 8'h00);
    idle(8);
    `CHECK(nchPullupEn, 2'h3)
    rdc(pcg_pkg::IDX_FLAG_ONE, 32'h00000004);
    rdc(pcg_pkg::IDX_PIN_DATA, 32'h000000A0);
    wr(pcg_pkg::IDX_FLAG_CLEAR, 8'h04);
    // Programming mode drives pin 6 from the serial clock line.
    progMode <= 1'b1;
    serialClockOe_n <= 1'b0;
    idle(8);
    `CHECK({pinOe_n[6], pinOut[6]}, 2'b01)
    `CHECK(serialClockIn, 1'b1)
    serialClockOe_n <= 1'b1;
    progMode <= 1'b0;
    // Comparator A takes pins 1 and 0 over; direction bits 1 and 0 cleared beforehand.
    wr(pcg_pkg::IDX_PIN_DATA, 8'h03);
    wr(pcg_pkg::IDX_DIRECTION, 8'hFC);
    wr(pcg_pkg::IDX_COMPARATOR, 8'h02);
    compAOut <= 1'b1;
    idle(2);
    `CHECK(refAOutEn, 1'b1)
    `CHECK(pinOe_n[1:0], 2'b01)
    `CHECK(pinOut[1:0], 2'b10)
    `CHECK(weakPullupEn[0], 1'b0)
    compAOut <= 1'b0;
    idle(2);
    `CHECK(pinOut[1], 1'b0)
    wr(pcg_pkg::IDX_COMPARATOR, 8'h00);
    idle(2);
    `CHECK(pinOut[1:0], 2'b11)
    `CHECK(refAOutEn, 1'b0)
    // Pin 3 feeds the timer clock only when selected.
    wr(pcg_pkg::IDX_OPTION, 8'hA0);
    extValue <= 8'h08;
    idle(8);
    `CHECK(timerZeroExtClock, 1'b1)
    `CHECK(weakPullupEn, 6'h00)
    extValue <= 8'h00;
    idle(8);
    `CHECK(timerZeroExtClock, 1'b0)
    wr(pcg_pkg::IDX_OPTION, 8'h80);
    extValue <= 8'h08;
    idle(8);
    `CHECK(timerZeroExtClock, 1'b0)
    end_sim();
  end
endmodule
